// *** verilog/ssr_defs.svh ***
`ifndef SSR_DEFS_SVH
`define SSR_DEFS_SVH

// ****************************************
// Device register map
// ****************************************
`define SSR_PRI_ADDR 7'h0a
`define SSR_SEC_ADDR 7'h0b
`define SSR_RES_LO_ADDR 7'h0c
`define SSR_RES_HI_ADDR 7'h0d
`define SSR_PRI_RST 8'h09
`define SSR_PRI_RSV 4'h9
`define SSR_SEC_RST 3'h0
`define SSR_PRI_ZERO 7
`define SSR_LED_GATE 6
`define SSR_TEST 5
`define SSR_DENS 4
`define SSR_BUSY 7
`define SSR_PULLUP 2
`define SSR_GAIN 1
`define SSR_RATE 0
`define SSR_PASS_WORD 16'h1bbf
`define SSR_FAIL_WORD 16'h0000
`define SSR_UNMAPPED 8'h00

// ****************************************
// Bound registers outside this block
// ****************************************
`define SSR_BOUND_LO 7'h20
`define SSR_BOUND_HI 7'h25
`define SSR_CEIL_HI_ADDR 7'h21

// ****************************************
// Timing
// ****************************************
`define SSR_CLK_HZ 25000000
`define SSR_TEST_MS 200
// The test length is a fixed cycle count: 200 ms on a 24 MHz clock.
`define SSR_TEST_REF_HZ 24000000
`define SSR_TEST_CYC (`SSR_TEST_MS * (`SSR_TEST_REF_HZ / 1000))
`define SSR_HOLD_US 1000
`define SSR_HOLD_CYC (`SSR_HOLD_US * (`SSR_CLK_HZ / 1000000))
`define SSR_SCLK_HALF 5'h10
`define SSR_DRST_CYC 5'h10
`define SSR_FRAME_BITS 4'hf
`define SSR_BYTE_BITS 3'h7

// ****************************************
// Pin filter lanes and idle levels
// ****************************************
`define SSR_PIN_NCS 0
`define SSR_PIN_SCLK 1
`define SSR_PIN_MOSI 2
`define SSR_PIN_RST 3
`define SSR_PIN_IDLE 4'h3

// ****************************************
// Controller register map
// ****************************************
`define SSR_C_TARGET 3'h0
`define SSR_C_WDATA 3'h1
`define SSR_C_CMD 3'h2
`define SSR_C_STATUS 3'h3
`define SSR_C_RDATA 3'h4
`define SSR_CMD_RD 0
`define SSR_CMD_WR 1
`define SSR_CMD_RST 2
`define SSR_CMD_CLR 3

`endif

// *** verilog/ssr_pkg.sv ***
`default_nettype none
package ssr_pkg;
  // ****************************************
  // State encodings
  // ****************************************
  typedef enum logic [4:0] {
    DS_IDLE = 5'h01,
    DS_ADDR = 5'h02,
    DS_WDATA = 5'h04,
    DS_RDATA = 5'h08,
    DS_WAIT = 5'h10
  } ssr_dstate_t;

  typedef enum logic [4:0] {
    CS_IDLE = 5'h01,
    CS_SEL = 5'h02,
    CS_SHIFT = 5'h04,
    CS_TAIL = 5'h08,
    CS_GAP = 5'h10
  } ssr_cstate_t;
endpackage
`default_nettype wire

// *** verilog/ssr_link_if.sv ***
`default_nettype none
interface ssr_link_if;
  // ****************************************
  // Four-wire serial port plus sensor reset
  // ****************************************
  logic ncs;
  logic sclk;
  logic mosi;
  logic misoOut;
  logic misoOe;
  logic miso;
  logic sensorReset;

  // The data-out line floats high through a pull-up when undriven.
  assign miso = misoOe ? misoOut : 1'b1;

  modport dev (
    input ncs,
    input sclk,
    input mosi,
    input sensorReset,
    output misoOut,
    output misoOe
  );

  modport ctl (
    output ncs,
    output sclk,
    output mosi,
    output sensorReset,
    input miso
  );
endinterface
`default_nettype wire

// *** verilog/ssr_dev.sv ***
// What this block does
// - LED steady on, or only when illumination needed.
// - Test trigger runs self test, 16-bit result.
// - Test fails if firmware image present.
// - Controller resets sensor first, reloads firmware after; here it refuses a test without a fresh reset and only flags the reload.
// - Test end restores defaults; configure afterwards.
// - Self test finishes in 4800000 cycles, 192 ms at 25 MHz.
// - Controller stays off serial port during test.
// - Density bit: 0 is 3500, 1 is 1800.
// - Busy flag reads 1 while bound writes wait.
// - Controller waits after ceiling high byte write.
// - Pull-up off bit disables port pull-ups.
// - Gain loop off uses exposure ceiling value.
// - Rate lock takes period from ceiling registers.
// - Result high byte 0x0d, low byte 0x0c.
// - Primary setup 0x0a, reset 0x09, bits 6:4.
// - Passing test leaves 0x1B and 0xBF.
`default_nettype none
`include "ssr_defs.svh"
module ssr_dev #(
  parameter int unsigned TEST_CYC = `SSR_TEST_CYC
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  ssr_link_if.dev link,
  input wire logic illumNeeded,
  input wire logic firmwareLoaded,
  input wire logic boundWriteBusy,
  output logic ledOn,
  output logic countDensitySelect,
  output logic portPullupOff,
  output logic gainLoopOff,
  output logic rateLock,
  output logic selfTestBusy
);
  import ssr_pkg::*;

  // Reset pattern of the primary setup register, read bit by bit.
  localparam logic [7:0] priReset = `SSR_PRI_RST;

  // ****************************************
  // Pin filtering
  // ****************************************
  logic [3:0] pinIn;
  logic [3:0] pinS1_q;
  logic [3:0] pinS2_q;
  logic [3:0] pinS3_q;
  logic [3:0] pin_q;
  logic sclkPrev_q;
  logic sclkRise;
  logic sclkFall;
  logic selLow;
  logic devRst;

  assign pinIn = {link.sensorReset, link.mosi, link.sclk, link.ncs};

  // A lane only changes once two later stages agree, so one glitchy
  // sample on a slow pin edge cannot count as a clock edge.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pinS1_q <= `SSR_PIN_IDLE;
      pinS2_q <= `SSR_PIN_IDLE;
      pinS3_q <= `SSR_PIN_IDLE;
      pin_q <= `SSR_PIN_IDLE;
      sclkPrev_q <= 1'b1;
    end else begin
      pinS1_q <= pinIn;
      pinS2_q <= pinS1_q;
      pinS3_q <= pinS2_q;
      pin_q <= (pinS2_q & ~(pinS2_q ^ pinS3_q)) |
               (pin_q & (pinS2_q ^ pinS3_q));
      sclkPrev_q <= pin_q[`SSR_PIN_SCLK];
    end
  end

  // Edge detection works on the filtered lanes only.
  assign sclkRise = pin_q[`SSR_PIN_SCLK] & ~sclkPrev_q;
  assign sclkFall = ~pin_q[`SSR_PIN_SCLK] & sclkPrev_q;
  assign selLow = ~pin_q[`SSR_PIN_NCS];
  assign devRst = pin_q[`SSR_PIN_RST];

  // ****************************************
  // Serial transaction engine
  // ****************************************
  ssr_dstate_t dstate_q;
  logic [2:0] bitCnt_q;
  logic [7:0] rxShift_q;
  logic [6:0] addr_q;
  logic [7:0] txShift_q;
  logic misoOut_q;
  logic misoOe_q;
  logic [7:0] rdByte;
  logic [7:0] wrData;
  logic wrStb;
  logic lastBit;
  logic testBusy_q;

  assign lastBit = bitCnt_q == `SSR_BYTE_BITS;
  assign wrData = {rxShift_q[6:0], pin_q[`SSR_PIN_MOSI]};
  assign wrStb = (dstate_q == DS_WDATA) && sclkRise && lastBit;

  // A byte is MSB first: bit 7 of the first byte set means write.
  // The port is deaf during a self test or a sensor reset.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      dstate_q <= DS_IDLE;
      bitCnt_q <= 3'h0;
      rxShift_q <= 8'h00;
      addr_q <= 7'h00;
      txShift_q <= 8'h00;
      misoOut_q <= 1'b0;
      misoOe_q <= 1'b0;
    end else if (!selLow || devRst || testBusy_q) begin
      dstate_q <= DS_IDLE;
      bitCnt_q <= 3'h0;
      misoOe_q <= 1'b0;
    end else begin
      unique case (dstate_q)
        DS_IDLE: begin
          dstate_q <= DS_ADDR;
          bitCnt_q <= 3'h0;
        end
        DS_ADDR: begin
          if (sclkRise) begin
            rxShift_q <= wrData;
            bitCnt_q <= bitCnt_q + 3'h1;
            if (lastBit) begin
              addr_q <= wrData[6:0];
              txShift_q <= rdByte;
              dstate_q <= rxShift_q[6] ? DS_WDATA : DS_RDATA;
            end
          end
        end
        DS_WDATA: begin
          if (sclkRise) begin
            rxShift_q <= wrData;
            bitCnt_q <= bitCnt_q + 3'h1;
            if (lastBit) begin
              dstate_q <= DS_WAIT;
            end
          end
        end
        DS_RDATA: begin
          if (sclkFall) begin
            misoOe_q <= 1'b1;
            misoOut_q <= txShift_q[7];
            txShift_q <= {txShift_q[6:0], 1'b0};
            bitCnt_q <= bitCnt_q + 3'h1;
            if (lastBit) begin
              dstate_q <= DS_WAIT;
            end
          end
        end
        DS_WAIT: begin
          dstate_q <= DS_WAIT;
        end
        default: begin
          dstate_q <= DS_IDLE;
        end
      endcase
    end
  end

  assign link.misoOut = misoOut_q;
  assign link.misoOe = misoOe_q;

  // ****************************************
  // Setup registers
  // ****************************************
  logic ledGate_q;
  logic density_q;
  logic pullupOff_q;
  logic gainOff_q;
  logic rateLock_q;
  logic [15:0] result_q;
  logic testDone;
  logic priWr;
  logic secWr;

  assign priWr = wrStb && (addr_q == `SSR_PRI_ADDR);
  assign secWr = wrStb && (addr_q == `SSR_SEC_ADDR);

  // Only bits 6 and 4 of the primary register are stored; bit 7 and the
  // reserved nibble always read back as their reset pattern.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ledGate_q <= priReset[`SSR_LED_GATE];
      density_q <= priReset[`SSR_DENS];
      pullupOff_q <= 1'b0;
      gainOff_q <= 1'b0;
      rateLock_q <= 1'b0;
    end else if (devRst || testDone) begin
      ledGate_q <= priReset[`SSR_LED_GATE];
      density_q <= priReset[`SSR_DENS];
      {pullupOff_q, gainOff_q, rateLock_q} <= `SSR_SEC_RST;
    end else begin
      if (priWr) begin
        ledGate_q <= wrData[`SSR_LED_GATE];
        density_q <= wrData[`SSR_DENS];
      end
      if (secWr) begin
        pullupOff_q <= wrData[`SSR_PULLUP];
        gainOff_q <= wrData[`SSR_GAIN];
        rateLock_q <= wrData[`SSR_RATE];
      end
    end
  end

  // Read data is captured at the end of the address byte.
  always_comb begin
    rdByte = `SSR_UNMAPPED;
    case (wrData[6:0])
      `SSR_PRI_ADDR: begin
        rdByte[3:0] = `SSR_PRI_RSV;
        rdByte[`SSR_LED_GATE] = ledGate_q;
        rdByte[`SSR_TEST] = testBusy_q;
        rdByte[`SSR_DENS] = density_q;
      end
      `SSR_SEC_ADDR: begin
        rdByte[`SSR_BUSY] = boundWriteBusy;
        rdByte[`SSR_PULLUP] = pullupOff_q;
        rdByte[`SSR_GAIN] = gainOff_q;
        rdByte[`SSR_RATE] = rateLock_q;
      end
      `SSR_RES_LO_ADDR: rdByte = result_q[7:0];
      `SSR_RES_HI_ADDR: rdByte = result_q[15:8];
      default: rdByte = `SSR_UNMAPPED;
    endcase
  end

  // ****************************************
  // Self test
  // ****************************************
  logic [31:0] testCnt_q;
  logic testFail_q;

  assign testDone = testBusy_q && (testCnt_q == 32'h0000_0000);

  // The whole test is modelled as a timed run; the image check is made
  // at the start, because loaded firmware corrupts the signature.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      testBusy_q <= 1'b0;
      testCnt_q <= 32'h0000_0000;
      testFail_q <= 1'b0;
      result_q <= 16'h0000;
    end else if (devRst) begin
      testBusy_q <= 1'b0;
    end else if (priWr && wrData[`SSR_TEST]) begin
      testBusy_q <= 1'b1;
      testCnt_q <= TEST_CYC - 32'h0000_0001;
      testFail_q <= firmwareLoaded;
    end else if (testDone) begin
      testBusy_q <= 1'b0;
      result_q <= testFail_q ? `SSR_FAIL_WORD : `SSR_PASS_WORD;
    end else if (testBusy_q) begin
      testCnt_q <= testCnt_q - 32'h0000_0001;
    end
  end

  // ****************************************
  // Registered user outputs
  // ****************************************
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ledOn <= 1'b1;
    end else begin
      ledOn <= ledGate_q ? illumNeeded : 1'b1;
    end
  end

  assign countDensitySelect = density_q;
  assign portPullupOff = pullupOff_q;
  assign gainLoopOff = gainOff_q;
  assign rateLock = rateLock_q;
  assign selfTestBusy = testBusy_q;
endmodule
`default_nettype wire

// *** verilog/ssr_ctl.sv ***
// Added by the designer: the strobed register port.
`default_nettype none
`include "ssr_defs.svh"
module ssr_ctl #(
  parameter int unsigned TEST_CYC = `SSR_TEST_CYC,
  parameter int unsigned HOLD_CYC = `SSR_HOLD_CYC
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  ssr_link_if.ctl link,
  input wire logic [2:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdata
);
  import ssr_pkg::*;

  // ****************************************
  // Data-in pin filter
  // ****************************************
  logic misoS1_q;
  logic misoS2_q;
  logic misoS3_q;
  logic miso_q;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      misoS1_q <= 1'b1;
      misoS2_q <= 1'b1;
      misoS3_q <= 1'b1;
      miso_q <= 1'b1;
    end else begin
      misoS1_q <= link.miso;
      misoS2_q <= misoS1_q;
      misoS3_q <= misoS2_q;
      if (misoS2_q == misoS3_q) begin
        miso_q <= misoS2_q;
      end
    end
  end

  // ****************************************
  // Command decode and guards
  // ****************************************
  ssr_cstate_t cstate_q;
  logic [6:0] target_q;
  logic [7:0] wdata_q;
  logic [7:0] rdata_q;
  logic cmdWr;
  logic goRd;
  logic goWr;
  logic isBound;
  logic isTest;
  logic accept;
  logic refuse;
  logic txDone;
  logic wasWr_q;
  logic wasTest_q;
  logic wasCeil_q;
  logic testRun_q;
  logic boundHold_q;
  logic resetFresh_q;
  logic reloadNeed_q;
  logic refused_q;
  logic [4:0] drstCnt_q;

  assign cmdWr = regWr && (regAddr == `SSR_C_CMD);
  assign goWr = cmdWr && regWdata[`SSR_CMD_WR];
  assign goRd = cmdWr && regWdata[`SSR_CMD_RD];
  assign isBound = (target_q >= `SSR_BOUND_LO) &&
                   (target_q <= `SSR_BOUND_HI);
  assign isTest = (target_q == `SSR_PRI_ADDR) && wdata_q[`SSR_TEST];
  // The port is closed while a test runs, while the sensor is held in
  // reset, and for bound writes until the frame hold has expired.
  assign accept = (goWr || goRd) && (cstate_q == CS_IDLE) &&
                  !testRun_q && (drstCnt_q == 5'h00) &&
                  !(goWr && isBound && boundHold_q) &&
                  !(goWr && isTest && !resetFresh_q);
  assign refuse = (goWr || goRd) && !accept;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      target_q <= 7'h00;
      wdata_q <= 8'h00;
    end else if (regWr && (regAddr == `SSR_C_TARGET)) begin
      target_q <= regWdata[6:0];
    end else if (regWr && (regAddr == `SSR_C_WDATA)) begin
      wdata_q <= regWdata;
    end
  end

  // ****************************************
  // Serial engine
  // ****************************************
  logic [4:0] divCnt_q;
  logic tick;
  logic [3:0] bitCnt_q;
  logic [15:0] txShift_q;
  logic [7:0] rxShift_q;
  logic ncs_q;
  logic sclk_q;
  logic mosi_q;
  logic [7:0] txData;

  assign tick = divCnt_q == (`SSR_SCLK_HALF - 5'h01);
  assign txDone = (cstate_q == CS_GAP) && tick;

  // Bit 7 of the primary setup register is never sent as one.
  always_comb begin
    txData = goWr ? wdata_q : 8'h00;
    if (target_q == `SSR_PRI_ADDR) begin
      txData[`SSR_PRI_ZERO] = 1'b0;
    end
  end

  // Clock idles high; data changes on the falling half, is sampled on
  // the rising one. Select stays low a half period past the last bit.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cstate_q <= CS_IDLE;
      divCnt_q <= 5'h00;
      bitCnt_q <= 4'h0;
      txShift_q <= 16'h0000;
      rxShift_q <= 8'h00;
      ncs_q <= 1'b1;
      sclk_q <= 1'b1;
      mosi_q <= 1'b0;
    end else begin
      divCnt_q <= (tick || cstate_q == CS_IDLE) ? 5'h00 :
                  divCnt_q + 5'h01;
      unique case (cstate_q)
        CS_IDLE: begin
          if (accept) begin
            cstate_q <= CS_SEL;
            ncs_q <= 1'b0;
            bitCnt_q <= 4'h0;
            txShift_q <= {goWr, target_q, txData};
          end
        end
        CS_SEL: begin
          if (tick) begin
            cstate_q <= CS_SHIFT;
          end
        end
        CS_SHIFT: begin
          if (tick && sclk_q) begin
            sclk_q <= 1'b0;
            mosi_q <= txShift_q[15];
            txShift_q <= {txShift_q[14:0], 1'b0};
          end else if (tick) begin
            sclk_q <= 1'b1;
            rxShift_q <= {rxShift_q[6:0], miso_q};
            bitCnt_q <= bitCnt_q + 4'h1;
            if (bitCnt_q == `SSR_FRAME_BITS) begin
              cstate_q <= CS_TAIL;
            end
          end
        end
        CS_TAIL: begin
          if (tick) begin
            ncs_q <= 1'b1;
            cstate_q <= CS_GAP;
          end
        end
        CS_GAP: begin
          if (tick) begin
            cstate_q <= CS_IDLE;
          end
        end
        default: begin
          cstate_q <= CS_IDLE;
        end
      endcase
    end
  end

  assign link.ncs = ncs_q;
  assign link.sclk = sclk_q;
  assign link.mosi = mosi_q;

  // ****************************************
  // Sequencing flags
  // ****************************************
  logic [31:0] waitCnt_q;
  logic rstCmd;

  assign rstCmd = cmdWr && regWdata[`SSR_CMD_RST] &&
                  (cstate_q == CS_IDLE);

  // The test and the ceiling hold share one down-counter; a test started
  // during the hold reloads it, so the hold lasts until the test ends.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wasWr_q <= 1'b0;
      wasTest_q <= 1'b0;
      wasCeil_q <= 1'b0;
      testRun_q <= 1'b0;
      boundHold_q <= 1'b0;
      waitCnt_q <= 32'h0000_0000;
      rdata_q <= 8'h00;
    end else begin
      if (accept) begin
        wasWr_q <= goWr;
        wasTest_q <= goWr && isTest;
        wasCeil_q <= goWr && (target_q == `SSR_CEIL_HI_ADDR);
      end
      if (txDone && wasTest_q) begin
        testRun_q <= 1'b1;
        waitCnt_q <= TEST_CYC;
      end else if (txDone && wasCeil_q) begin
        boundHold_q <= 1'b1;
        waitCnt_q <= HOLD_CYC;
      end else if (waitCnt_q != 32'h0000_0000) begin
        waitCnt_q <= waitCnt_q - 32'h0000_0001;
      end else begin
        testRun_q <= 1'b0;
        boundHold_q <= 1'b0;
      end
      if (txDone && !wasWr_q) begin
        rdata_q <= rxShift_q;
      end
    end
  end

  // Reset pulse, fresh-reset tracking, reload and refusal flags.
  // A setting event wins over a clear in the same cycle.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      drstCnt_q <= 5'h00;
      resetFresh_q <= 1'b0;
      reloadNeed_q <= 1'b0;
      refused_q <= 1'b0;
    end else begin
      if (rstCmd) begin
        drstCnt_q <= `SSR_DRST_CYC;
      end else if (drstCnt_q != 5'h00) begin
        drstCnt_q <= drstCnt_q - 5'h01;
      end
      if (rstCmd) begin
        resetFresh_q <= 1'b1;
      end else if (accept) begin
        resetFresh_q <= 1'b0;
      end
      if (txDone && wasTest_q) begin
        reloadNeed_q <= 1'b1;
      end else if (cmdWr && regWdata[`SSR_CMD_CLR]) begin
        reloadNeed_q <= 1'b0;
      end
      if (refuse) begin
        refused_q <= 1'b1;
      end else if (accept) begin
        refused_q <= 1'b0;
      end
    end
  end

  assign link.sensorReset = drstCnt_q != 5'h00;

  // ****************************************
  // Register read port
  // ****************************************
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      regRdata <= 8'h00;
    end else if (regRd) begin
      case (regAddr)
        `SSR_C_TARGET: regRdata <= {1'b0, target_q};
        `SSR_C_WDATA: regRdata <= wdata_q;
        `SSR_C_STATUS: regRdata <= {3'h0, refused_q, reloadNeed_q,
                                    boundHold_q, testRun_q,
                                    cstate_q != CS_IDLE};
        `SSR_C_RDATA: regRdata <= rdata_q;
        default: regRdata <= 8'h00;
      endcase
    end else begin
      regRdata <= 8'h00;
    end
  end
endmodule
`default_nettype wire

// *** tb/ssr_assertions.sv ***
`default_nettype none
module ssr_assertions (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ncs,
  input wire logic sclk,
  input wire logic mosi,
  input wire logic misoOut,
  input wire logic misoOe,
  input wire logic miso,
  input wire logic sensorReset
);
  logic sclk_q;
  logic [4:0] bitCnt_q;

  // Clock rises per frame, seen a cycle late; the tail half absorbs that.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sclk_q <= 1'b1;
      bitCnt_q <= 5'h0;
    end else begin
      sclk_q <= sclk;
      if (ncs) begin
        bitCnt_q <= 5'h0;
      end else if (sclk && !sclk_q) begin
        bitCnt_q <= bitCnt_q + 5'h1;
      end
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  sequence halfLow;
    !sclk [*8];
  endsequence
  sequence pulseHeld;
    sensorReset [*8];
  endsequence

  // Framing and pacing of the wire.
  idle_clock_high_a: assert property (ncs |-> sclk)
    else $error("clock low outside frame");
  frame_bits_a: assert property ($rose(ncs) |-> bitCnt_q == 5'h10)
    else $error("frame not 16 bits");
  half_period_a: assert property ($fell(sclk) |-> halfLow ##[8:9] sclk)
    else $error("bad half period");
  data_stable_a: assert property ($rose(sclk) |-> $stable(mosi))
    else $error("data moved at clock rise");
  frame_gap_a: assert property ($rose(ncs) |-> ncs [*8])
    else $error("gap too short");
  drive_in_frame_a: assert property ($rose(misoOe) |-> !ncs)
    else $error("data driven outside frame");
  drive_release_a: assert property ($rose(ncs) |-> ##[0:8] !misoOe)
    else $error("data line not released");
  // The sensor reset pulse has a fixed length and silences the port.
  reset_pulse_a: assert property (
    $rose(sensorReset) |-> pulseHeld ##[8:9] !sensorReset)
    else $error("reset pulse length wrong");
  reset_quiet_a: assert property (sensorReset |-> ncs)
    else $error("traffic during sensor reset");
endmodule
`default_nettype wire

// *** tb/sensor_setup_and_selftest_regs_tb.sv ***
`default_nettype none
`include "ssr_defs.svh"
module sensor_setup_and_selftest_regs_tb;
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************
  // Signals and instances
  // ****************************************
  localparam int TC = 200;
  typedef struct packed {
    logic [6:0] a;
    logic [7:0] d;
    logic illum;
    logic bwb;
    logic [7:0] r;
    logic [4:0] o;
  } ssr_row_t;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic illumNeeded = 1'b0;
  logic firmwareLoaded = 1'b0;
  logic boundWriteBusy = 1'b0;
  logic [2:0] regAddr = 3'h0;
  logic [7:0] regWdata = 8'h00;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [7:0] regRdata;
  logic ledOn, countDensitySelect, portPullupOff, gainLoopOff, rateLock;
  logic selfTestBusy;
  logic [15:0] shiftIn, frameSeen;
  int errors = 0;
  int n_tests = 0;
  int tRise = 0;
  int tFall = 0;
  // Outputs are {led, density, pull-up off, gain off, rate lock}.
  ssr_row_t rows [7] = '{
    '{7'h0a, 8'h50, 1'b0, 1'b0, 8'h59, 5'h08},
    '{7'h0a, 8'h50, 1'b1, 1'b0, 8'h59, 5'h18},
    '{7'h0a, 8'h8f, 1'b0, 1'b0, 8'h09, 5'h10},
    '{7'h0b, 8'h07, 1'b0, 1'b0, 8'h07, 5'h17},
    '{7'h0b, 8'hfa, 1'b0, 1'b1, 8'h82, 5'h12},
    '{7'h0b, 8'h00, 1'b0, 1'b0, 8'h00, 5'h10},
    '{7'h30, 8'h5a, 1'b0, 1'b0, 8'h00, 5'h10}};

  ssr_link_if link ();
  ssr_dev #(.TEST_CYC(TC)) ssr_dev_i (
    .clk_sys(clk_sys), .rst_n(rst_n), .link(link.dev),
    .illumNeeded(illumNeeded), .firmwareLoaded(firmwareLoaded),
    .boundWriteBusy(boundWriteBusy), .ledOn(ledOn),
    .countDensitySelect(countDensitySelect), .portPullupOff(portPullupOff),
    .gainLoopOff(gainLoopOff), .rateLock(rateLock),
    .selfTestBusy(selfTestBusy));
  ssr_ctl #(.TEST_CYC(TC), .HOLD_CYC(50)) ssr_ctl_i (
    .clk_sys(clk_sys), .rst_n(rst_n), .link(link.ctl),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
    .regRd(regRd), .regRdata(regRdata));
  ssr_assertions ssr_assertions_i (
    .clk_sys(clk_sys), .rst_n(rst_n), .ncs(link.ncs), .sclk(link.sclk),
    .mosi(link.mosi), .misoOut(link.misoOut), .misoOe(link.misoOe),
    .miso(link.miso), .sensorReset(link.sensorReset));

  // Clock at 25 MHz.
  always #20 clk_sys = ~clk_sys;
  // Capture each serial word on the wire, first bit in at the top.
  always @(posedge link.sclk)
    if (!link.ncs) shiftIn = {shiftIn[14:0], link.mosi};
  always @(posedge link.ncs) frameSeen = shiftIn;
  // Time stamps bracket the self test as the device reports it.
  always @(posedge selfTestBusy) tRise = int'($time);
  always @(negedge selfTestBusy) tFall = int'($time);

  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  function automatic logic [7:0] pins();
    return {3'h0, ledOn, countDensitySelect, portPullupOff, gainLoopOff,
      rateLock};
  endfunction

  // A strobe is dropped and one idle cycle passes, so calls chain safely.
  task automatic wr(logic [2:0] a, logic [7:0] d);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk_sys);
    regWr <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic rd(logic [2:0] a, output logic [7:0] d);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk_sys);
    regRd <= 1'b0;
    #1;
    d = regRdata;
    @(posedge clk_sys);
  endtask

  // Poll until neither a transfer nor a self test is running.
  task automatic idle();
    logic [7:0] s = 8'hff;
    for (int k = 0; k < 3000 && s[1:0] !== 2'b00; k++) begin
      rd(`SSR_C_STATUS, s);
    end
    if (s[1:0] !== 2'b00) begin
      errors++;
      $display("BAD idle expected 00 seen %b", s[1:0]);
    end
  endtask

  task automatic swr(logic [6:0] a, logic [7:0] d);
    wr(`SSR_C_TARGET, {1'b0, a});
    wr(`SSR_C_WDATA, d);
    wr(`SSR_C_CMD, 8'h02);
    idle();
  endtask

  task automatic srd(logic [6:0] a, output logic [7:0] d);
    wr(`SSR_C_TARGET, {1'b0, a});
    wr(`SSR_C_CMD, 8'h01);
    idle();
    rd(`SSR_C_RDATA, d);
  endtask

  // The pulse lasts 16 cycles and the device sees its end a few later;
  // status does not show it, so the wait is counted out here.
  task automatic sreset();
    wr(`SSR_C_CMD, 8'h04);
    idle();
    repeat (24) @(posedge clk_sys);
  endtask

  task automatic conclude();
    if (errors == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    logic [7:0] v;
    int d;
    repeat (3) @(posedge clk_sys);
    chk("reset pins", 8'h10, pins());
    chk("reset rdata", 8'h00, regRdata);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    sreset();
    srd(`SSR_PRI_ADDR, v);
    chk("primary reset", 8'h09, v);
    srd(`SSR_SEC_ADDR, v);
    chk("secondary reset", 8'h00, v);
    foreach (rows[i]) begin
      illumNeeded <= rows[i].illum;
      boundWriteBusy <= rows[i].bwb;
      swr(rows[i].a, rows[i].d);
      srd(rows[i].a, v);
      chk("readback", rows[i].r, v);
      chk("pins", {3'h0, rows[i].o}, pins());
      chk("frame head", {1'b0, rows[i].a}, frameSeen[15:8]);
    end
    // Passing self test; the length is judged from the device's flag.
    sreset();
    swr(`SSR_PRI_ADDR, 8'h20);
    d = (tFall - tRise) / 40;
    n_tests++;
    if (d < TC - 2 || d > TC + 2) begin
      errors++;
      $display("BAD test length expected %0d seen %0d", TC, d);
    end
    srd(`SSR_RES_HI_ADDR, v);
    chk("result high", 8'h1b, v);
    srd(`SSR_RES_LO_ADDR, v);
    chk("result low", 8'hbf, v);
    srd(`SSR_PRI_ADDR, v);
    chk("defaults", 8'h09, v);
    rd(`SSR_C_STATUS, v);
    chk("reload flag", 8'h08, v & 8'h08);
    wr(`SSR_C_CMD, 8'h08);
    rd(`SSR_C_STATUS, v);
    chk("reload clear", 8'h00, v & 8'h08);
    swr(`SSR_RES_HI_ADDR, 8'h00);
    srd(`SSR_RES_HI_ADDR, v);
    chk("result read-only", 8'h1b, v);
    // A bound write right after the ceiling high byte is held back.
    swr(`SSR_CEIL_HI_ADDR, 8'h0e);
    swr(`SSR_BOUND_LO, 8'h40);
    rd(`SSR_C_STATUS, v);
    chk("bound hold", 8'h14, v & 8'h14);
    // A loaded firmware image makes the test fail.
    firmwareLoaded <= 1'b1;
    sreset();
    swr(`SSR_PRI_ADDR, 8'h20);
    srd(`SSR_RES_HI_ADDR, v);
    chk("fail high", 8'h00, v);
    srd(`SSR_RES_LO_ADDR, v);
    chk("fail low", 8'h00, v);
    // A start with no fresh reset before it is refused.
    swr(`SSR_PRI_ADDR, 8'h20);
    rd(`SSR_C_STATUS, v);
    chk("refused start", 8'h10, v & 8'h10);
    conclude();
  end

  // Watchdog well beyond the roughly 16000 cycles the sequence needs.
  initial begin
    #(60000 * 40);
    errors++;
    conclude();
  end
endmodule
`default_nettype wire
